// ===== verilog/ipl_pkg.sv
package ipl_pkg;

    // Slave addresses selected by the strap
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h1D;
    localparam logic [6:0] ADDR_STRAP_LOW  = 7'h53;

    // Register map
    localparam logic [7:0] REG_ENABLE      = 8'h2E;
    localparam logic [7:0] REG_ROUTE       = 8'h2F;
    localparam logic [7:0] REG_CAUSE       = 8'h30;
    localparam logic [7:0] REG_FORMAT      = 8'h31;
    localparam logic [7:0] REG_DATA_FIRST  = 8'h32;
    localparam logic [7:0] REG_DATA_LAST   = 8'h37;

    // Reset values, and the value read at unmapped addresses
    localparam logic [7:0] ENABLE_RST      = 8'h00;
    localparam logic [7:0] ROUTE_RST       = 8'h00;
    localparam logic [7:0] FORMAT_RST      = 8'h00;
    localparam logic [7:0] FLAGS_RST       = 8'h00;
    localparam logic [7:0] PTR_RST         = 8'h00;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // Field layout
    localparam int unsigned FMT_INVERT_BIT = 5;
    localparam int unsigned DATA_READY_BIT = 7;
    localparam logic [7:0] DATA_FLAG_MASK  = 8'h83;

    // Bus framing
    localparam logic [3:0] BYTE_BITS       = 4'h8;
    localparam logic [3:0] CNT_RST         = 4'h0;
    localparam logic [7:0] PTR_STEP        = 8'h01;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_REG  = 7'b0000100,
        ST_WDAT = 7'b0001000,
        ST_RDAT = 7'b0010000,
        ST_ACK  = 7'b0100000,
        ST_MACK = 7'b1000000
    } ipl_state_e;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic sda;
        logic start;
        logic stop;
    } ipl_line_s;

endpackage : ipl_pkg

// ===== verilog/ipl_line_sampler.sv
`timescale 1ns/1ps
module ipl_line_sampler
    import ipl_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Bus lines
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Decoded line events
    output ipl_line_s line_o
);
    logic scl_q_reg;
    logic sda_q_reg;
    logic scl_d_reg;
    logic sda_d_reg;

    // Oversampled at the core clock, far above the fastest bus rate
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_q_reg <= scl_i; // R2
            sda_q_reg <= sda_i;
            scl_d_reg <= scl_q_reg;
            sda_d_reg <= sda_q_reg;
        end
    end

    assign line_o.scl_rise = scl_q_reg && !scl_d_reg;
    assign line_o.scl_fall = !scl_q_reg && scl_d_reg;
    assign line_o.sda      = sda_q_reg;
    assign line_o.start    = scl_q_reg && scl_d_reg && sda_d_reg && !sda_q_reg;
    assign line_o.stop     = scl_q_reg && scl_d_reg && !sda_d_reg && sda_q_reg;

endmodule : ipl_line_sampler

// ===== verilog/ipl_irq_router.sv
`timescale 1ns/1ps
module ipl_irq_router
    import ipl_pkg::*;
#(
    parameter int unsigned N = 8
)
(
    // Flags and configuration
    input  wire logic [N-1:0] flags_i,
    input  wire logic [N-1:0] enable_i,
    input  wire logic [N-1:0] route_i,
    input  wire logic         invert_i,
    // Pin levels
    output logic              first_o,
    output logic              second_o
);
    logic [N-1:0] to_first;
    logic [N-1:0] to_second;

    for (genvar i = 0; i < N; i++)
    begin : g_route
        assign to_first[i]  = flags_i[i] && enable_i[i] && !route_i[i]; // R9
        assign to_second[i] = flags_i[i] && enable_i[i] && route_i[i]; // R10
    end

    // Shared pins simply OR their sources
    assign first_o  = (|to_first) ^ invert_i; // R11
    assign second_o = (|to_second) ^ invert_i; // R8

endmodule : ipl_irq_router

// ===== verilog/ipl_port_irq.sv
// Function
// R1: Chip select high puts the host port into two-wire slave mode.
// R2: Bus runs at standard 100 kHz or fast 400 kHz, never faster.
// R3: Strap high answers address 0x1D, write byte 0x3A, read byte 0x3B.
// R4: Strap low answers address 0x53, write byte 0xA6, read byte 0xA7.
// R5: Single-byte and multi-byte register reads and writes are supported.
// R6: Register pointer steps by one after every data byte.
// R7: Two separate push-pull interrupt outputs.
// R8: Outputs active high after reset; format invert bit makes both active low.
// R9: A function reaches a pin only while its enable bit is set.
// R10: Routing bit picks the first or second interrupt pin per function.
// R11: All functions run together; those on one pin are combined.
// R12: Host sets up functions and routing before enabling interrupts.
// R13: Host disables, reconfigures, then re-enables to change an interrupt.
// R14: Data flags stay latched until data reads leave the condition false.
// R15: Reading the cause register clears non-data flags and reports fired events.
// R16: New-sample flag set while fresh sample waits, cleared when none remains.
// R17: Registers are eight bits, selected by a register byte after address.
`timescale 1ns/1ps
module ipl_port_irq
    import ipl_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_N_I,
    // Host port pins
    input  wire logic        CS_I,
    input  wire logic        ADDRESS_SELECT_STRAP_I,
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_O,
    // Sensor core side
    input  wire logic [47:0] SAMPLE_I,
    input  wire logic [7:0]  DATA_COND_I,
    input  wire logic [7:0]  EVENT_I,
    output logic             DATA_READ_O,
    output logic [7:0]       FORMAT_O,
    // Interrupt pins
    output logic             IRQ_OUT_FIRST_O,
    output logic             IRQ_OUT_SECOND_O
);
    ipl_line_s  ln;
    ipl_state_e st_reg;
    ipl_state_e st_next;
    ipl_state_e after_reg;
    ipl_state_e after_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] sh_reg;
    logic [7:0] sh_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic       oe_reg;
    logic       oe_next;
    logic       strap_reg;
    logic       sda_o_reg;
    logic       data_rd_reg;
    logic [7:0] en_reg;
    logic [7:0] route_reg;
    logic [7:0] fmt_reg;
    logic [7:0] flags_reg;
    logic       irq1_reg;
    logic       irq2_reg;
    logic       pin_first;
    logic       pin_second;

    ipl_line_sampler u_sampler (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .scl_i   (SCL_I),
        .sda_i   (SDA_I),
        .line_o  (ln)
    );

    // Decode
    wire        bus_ok     = CS_I && !ln.stop && !ln.start;
    wire        byte_done  = cnt_reg == BYTE_BITS;
    wire        end_byte   = ln.scl_fall && byte_done;
    wire [6:0]  dev_addr   = strap_reg ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
    wire        addr_match = sh_reg[7:1] == dev_addr;
    wire        wr_commit  = bus_ok && st_reg == ST_WDAT && end_byte;
    wire        rd_load    = bus_ok && ln.scl_fall
                             && ((st_reg == ST_ACK && after_reg == ST_RDAT)
                                 || st_reg == ST_MACK);
    wire [7:0]  data_off   = ptr_reg - REG_DATA_FIRST;
    wire        data_hit   = ptr_reg >= REG_DATA_FIRST && ptr_reg <= REG_DATA_LAST;
    wire [7:0]  data_byte  = SAMPLE_I[{data_off[2:0], 3'h0} +: 8];
    wire [7:0]  rd_byte    = (ptr_reg == REG_ENABLE) ? en_reg
                           : (ptr_reg == REG_ROUTE)  ? route_reg
                           : (ptr_reg == REG_CAUSE)  ? flags_reg
                           : (ptr_reg == REG_FORMAT) ? fmt_reg
                           : data_hit                ? data_byte
                           : UNMAPPED_READ;
    wire        data_rd    = rd_load && data_hit;
    wire        cause_rd   = rd_load && ptr_reg == REG_CAUSE;
    wire        inv        = fmt_reg[FMT_INVERT_BIT];

    // Flags: the set term wins over a clear in the same cycle
    wire [7:0]  set_flags  = ((DATA_COND_I & DATA_FLAG_MASK)
                             | (EVENT_I & ~DATA_FLAG_MASK)) & en_reg;
    wire [7:0]  clr_data   = data_rd ? (DATA_FLAG_MASK & ~DATA_COND_I) : 8'h00; // R14
    wire [7:0]  clr_cause  = cause_rd ? ~DATA_FLAG_MASK : 8'h00; // R15
    wire [7:0]  flags_next = (flags_reg & ~(clr_data | clr_cause)) | set_flags; // R16

    always_comb
    begin
        st_next    = st_reg;
        after_next = after_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        tx_next    = tx_reg;
        oe_next    = oe_reg;
        ptr_next   = ptr_reg;
        if (!CS_I || ln.stop) // R1
        begin
            st_next = ST_IDLE;
            oe_next = 1'b0;
        end
        else if (ln.start)
        begin
            st_next  = ST_ADDR;
            cnt_next = CNT_RST;
            oe_next  = 1'b0;
        end
        else
        begin
            unique case (st_reg)
                ST_IDLE:
                begin
                    st_next = ST_IDLE;
                end
                ST_ADDR, ST_REG, ST_WDAT:
                begin
                    if (ln.scl_rise)
                    begin
                        sh_next  = {sh_reg[6:0], ln.sda};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (end_byte)
                    begin
                        cnt_next = CNT_RST;
                        if (st_reg == ST_ADDR && !addr_match) // R3 R4
                        begin
                            st_next = ST_IDLE;
                        end
                        else
                        begin
                            st_next = ST_ACK;
                            oe_next = 1'b1;
                            if (st_reg == ST_ADDR)
                            begin
                                after_next = sh_reg[0] ? ST_RDAT : ST_REG;
                            end
                            else
                            begin
                                after_next = ST_WDAT;
                            end
                            if (st_reg == ST_REG)
                            begin
                                ptr_next = sh_reg; // R17
                            end
                            if (st_reg == ST_WDAT)
                            begin
                                ptr_next = ptr_reg + PTR_STEP; // R6
                            end
                        end
                    end
                end
                ST_ACK:
                begin
                    if (ln.scl_fall)
                    begin
                        st_next  = after_reg;
                        cnt_next = CNT_RST;
                        oe_next  = 1'b0;
                        if (after_reg == ST_RDAT)
                        begin
                            tx_next  = rd_byte;
                            oe_next  = !rd_byte[7];
                            ptr_next = ptr_reg + PTR_STEP; // R6
                        end
                    end
                end
                ST_RDAT:
                begin
                    if (ln.scl_rise)
                    begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (end_byte)
                    begin
                        st_next = ST_MACK;
                        oe_next = 1'b0;
                    end
                    else if (ln.scl_fall)
                    begin
                        tx_next = {tx_reg[6:0], 1'b0};
                        oe_next = !tx_reg[6];
                    end
                end
                ST_MACK:
                begin
                    // A not-acknowledge ends the burst; wait for stop or restart
                    if (ln.scl_rise && ln.sda)
                    begin
                        st_next = ST_IDLE;
                    end
                    else if (ln.scl_fall)
                    begin
                        st_next  = ST_RDAT;
                        cnt_next = CNT_RST;
                        tx_next  = rd_byte;
                        oe_next  = !rd_byte[7];
                        ptr_next = ptr_reg + PTR_STEP; // R5
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            st_reg    <= ST_IDLE;
            after_reg <= ST_IDLE;
            cnt_reg   <= CNT_RST;
            sh_reg    <= 8'h00;
            tx_reg    <= 8'h00;
            oe_reg    <= 1'b0;
            ptr_reg   <= PTR_RST;
        end
        else
        begin
            st_reg    <= st_next;
            after_reg <= after_next;
            cnt_reg   <= cnt_next;
            sh_reg    <= sh_next;
            tx_reg    <= tx_next;
            oe_reg    <= oe_next;
            ptr_reg   <= ptr_next;
        end
    end

    // Strap caught while reset is held, frozen afterwards
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            strap_reg <= ADDRESS_SELECT_STRAP_I;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            en_reg    <= ENABLE_RST;
            route_reg <= ROUTE_RST;
            fmt_reg   <= FORMAT_RST;
            flags_reg <= FLAGS_RST;
        end
        else
        begin
            en_reg    <= (wr_commit && ptr_reg == REG_ENABLE) ? sh_reg : en_reg; // R9
            route_reg <= (wr_commit && ptr_reg == REG_ROUTE) ? sh_reg : route_reg; // R10
            fmt_reg   <= (wr_commit && ptr_reg == REG_FORMAT) ? sh_reg : fmt_reg; // R8
            flags_reg <= flags_next;
        end
    end

    ipl_irq_router #(
        .N (8)
    ) u_router (
        .flags_i  (flags_reg),
        .enable_i (en_reg),
        .route_i  (route_reg),
        .invert_i (inv),
        .first_o  (pin_first),
        .second_o (pin_second)
    );

    // Pins stay driven both ways; reset leaves them at the inactive level
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            irq1_reg    <= 1'b0;
            irq2_reg    <= 1'b0;
            sda_o_reg   <= 1'b0;
            data_rd_reg <= 1'b0;
        end
        else
        begin
            irq1_reg    <= pin_first; // R7
            irq2_reg    <= pin_second; // R7
            sda_o_reg   <= 1'b0;
            data_rd_reg <= data_rd;
        end
    end

    assign SDA_O            = sda_o_reg;
    assign SDA_OE_O         = oe_reg;
    assign DATA_READ_O      = data_rd_reg;
    assign FORMAT_O         = fmt_reg;
    assign IRQ_OUT_FIRST_O  = irq1_reg;
    assign IRQ_OUT_SECOND_O = irq2_reg;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    cs_quiet_a: assert property ( // R1
        !CS_I |=> !SDA_OE_O && st_reg == ST_IDLE)
        else $error("slave active outside two-wire mode");
    addr_high_a: assert property ( // R3
        st_reg == ST_ADDR && end_byte && bus_ok && strap_reg
        && sh_reg[7:1] == ADDR_STRAP_HIGH |=> SDA_OE_O && st_reg == ST_ACK)
        else $error("no acknowledge for strap-high address");
    addr_low_a: assert property ( // R4
        st_reg == ST_ADDR && end_byte && bus_ok && !strap_reg
        && sh_reg[7:1] == ADDR_STRAP_LOW |=> SDA_OE_O && st_reg == ST_ACK)
        else $error("no acknowledge for strap-low address");
    read_step_a: assert property ( // R5
        rd_load |=> ptr_reg == $past(ptr_reg) + PTR_STEP && DATA_READ_O == $past(data_rd))
        else $error("read did not advance pointer");
    write_step_a: assert property ( // R6
        wr_commit |=> ptr_reg == $past(ptr_reg) + PTR_STEP ##1 st_reg != ST_WDAT || SDA_OE_O)
        else $error("write did not advance pointer");
    polarity_a: assert property ( // R8
        |(flags_reg & en_reg & ~route_reg) |=> IRQ_OUT_FIRST_O != $past(inv))
        else $error("first pin not at active level");
    blocked_a: assert property ( // R9
        en_reg == 8'h00 |=> IRQ_OUT_FIRST_O == $past(inv) && IRQ_OUT_SECOND_O == $past(inv))
        else $error("disabled function reached a pin");
    route_second_a: assert property ( // R10
        |(flags_reg & en_reg & route_reg) |=> IRQ_OUT_SECOND_O != $past(inv))
        else $error("second pin not at active level");
    data_hold_a: assert property ( // R14
        !data_rd |=> (flags_reg & $past(flags_reg) & DATA_FLAG_MASK)
        == ($past(flags_reg) & DATA_FLAG_MASK))
        else $error("data flag dropped without data read");
    cause_clear_a: assert property ( // R15
        cause_rd && EVENT_I == 8'h00 |=> (flags_reg & ~DATA_FLAG_MASK) == 8'h00)
        else $error("cause read left event flags set");
    sample_set_a: assert property ( // R16
        DATA_COND_I[DATA_READY_BIT] && en_reg[DATA_READY_BIT] |=> flags_reg[DATA_READY_BIT])
        else $error("new-sample flag not set");
    write_store_a: assert property ( // R17
        wr_commit && ptr_reg == REG_ROUTE |=> route_reg == $past(sh_reg))
        else $error("register write not stored");

endmodule : ipl_port_irq

// ===== verification/ipl_host_model.sv
`timescale 1ns/1ps
module ipl_host_model
(
    // Clock
    input  wire logic clk_i,
    // Bus lines
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // 125 cycles of 20 ns per bit keeps the bus at 400 kHz
    localparam int LOW_CYC  = 65;
    localparam int HIGH_CYC = 55;
    // Data moves only well after the clock has fallen
    localparam int HOLD_CYC = 5;

    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cyc

    task automatic put_bit(input logic b);
        sda_o = b;
        wait_cyc(LOW_CYC);
        scl_o = 1'b1;
        wait_cyc(HIGH_CYC);
        scl_o = 1'b0;
        wait_cyc(HOLD_CYC);
    endtask : put_bit

    task automatic get_bit(output logic b);
        sda_o = 1'b1;
        wait_cyc(LOW_CYC);
        scl_o = 1'b1;
        wait_cyc(HIGH_CYC / 2);
        b = sda_i;
        wait_cyc(HIGH_CYC - HIGH_CYC / 2);
        scl_o = 1'b0;
        wait_cyc(HOLD_CYC);
    endtask : get_bit

    // Serves as a repeated start as well
    task automatic start_cond();
        sda_o = 1'b1;
        wait_cyc(LOW_CYC);
        scl_o = 1'b1;
        wait_cyc(HIGH_CYC);
        sda_o = 1'b0;
        wait_cyc(HIGH_CYC);
        scl_o = 1'b0;
        wait_cyc(HOLD_CYC);
    endtask : start_cond

    task automatic stop_cond();
        sda_o = 1'b0;
        wait_cyc(LOW_CYC);
        scl_o = 1'b1;
        wait_cyc(HIGH_CYC);
        sda_o = 1'b1;
        wait_cyc(HIGH_CYC);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask : send_byte

    task automatic recv_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(last);
    endtask : recv_byte

    task automatic write_regs(input logic [6:0] addr, input logic [7:0] reg_addr,
                              input logic [63:0] data, input int n, output logic ok);
        logic a;
        start_cond();
        send_byte({addr, 1'b0}, a);
        ok = a;
        send_byte(reg_addr, a);
        ok &= a;
        for (int i = 0; i < n; i++)
        begin
            send_byte(data[8*i +: 8], a);
            ok &= a;
        end
        stop_cond();
    endtask : write_regs

    task automatic read_regs(input logic [6:0] addr, input logic [7:0] reg_addr,
                             input int n, output logic [63:0] data, output logic ok);
        logic       a;
        logic [7:0] b;
        data = '0;
        start_cond();
        send_byte({addr, 1'b0}, a);
        ok = a;
        send_byte(reg_addr, a);
        ok &= a;
        start_cond();
        send_byte({addr, 1'b1}, a);
        ok &= a;
        for (int i = 0; i < n; i++)
        begin
            recv_byte(i == n - 1, b);
            data[8*i +: 8] = b;
        end
        stop_cond();
    endtask : read_regs
endmodule : ipl_host_model

// ===== verification/ipl_port_irq_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module ipl_port_irq_tb
    import ipl_pkg::*;
;
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] route;
        logic [7:0] fmt;
        logic [7:0] evt;
        logic       first;
        logic       second;
    } ipl_row_s;

    logic        ref_clk;
    logic        rst_n;
    logic        cs;
    logic        strap;
    logic        scl;
    logic        sda_m;
    wire logic   sda_wire;
    logic [47:0] sample;
    logic [7:0]  data_cond;
    logic [7:0]  event_in;
    logic        sda_out;
    logic        sda_oe;
    logic        data_read;
    logic [7:0]  format;
    logic        irq_first;
    logic        irq_second;
    logic        ok;
    logic [63:0] rd;
    int          miscompares;
    int          total_checks;
    int          data_pulses = 0;

    // Pull-up on the wire; a driving device shows its SDA_O level
    assign sda_wire = sda_m & (~sda_oe | sda_out);

    ipl_row_s rows [3] = '{
        '{8'h0C, 8'h08, 8'h00, 8'h0C, 1'b1, 1'b1},
        '{8'h04, 8'h00, 8'h20, 8'h14, 1'b0, 1'b1},
        '{8'h30, 8'h00, 8'h00, 8'h30, 1'b1, 1'b0}
    };

    ipl_port_irq u_dut (
        .REF_CLK_I              (ref_clk),
        .RST_N_I                (rst_n),
        .CS_I                   (cs),
        .ADDRESS_SELECT_STRAP_I (strap),
        .SCL_I                  (scl),
        .SDA_I                  (sda_wire),
        .SDA_O                  (sda_out),
        .SDA_OE_O               (sda_oe),
        .SAMPLE_I               (sample),
        .DATA_COND_I            (data_cond),
        .EVENT_I                (event_in),
        .DATA_READ_O            (data_read),
        .FORMAT_O               (format),
        .IRQ_OUT_FIRST_O        (irq_first),
        .IRQ_OUT_SECOND_O       (irq_second)
    );

    ipl_host_model u_host (
        .clk_i (ref_clk),
        .sda_i (sda_wire),
        .scl_o (scl),
        .sda_o (sda_m)
    );

    always #10 ref_clk = ~ref_clk;

    // One count per data byte handed to the host
    always @(posedge ref_clk)
    begin
        if (data_read)
            data_pulses++;
    end

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic pulse_event(input logic [7:0] e);
        settle(1);
        event_in = e;
        settle(1);
        event_in = 8'h00;
        settle(4);
    endtask : pulse_event

    task automatic print_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end

    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        cs = 1'b1;
        strap = 1'b1;
        sample = 48'h665544332211;
        data_cond = 8'h00;
        event_in = 8'h00;
        miscompares = 0;
        total_checks = 0;
        settle(20);
        rst_n = 1'b1;
        settle(5);
        `CHK(irq_first, 1'b0)
        for (int k = 0; k < 3; k++)
        begin
            // Disable first, then route and format, then enable
            u_host.write_regs(ADDR_STRAP_HIGH, REG_ENABLE,
                              {32'h0, rows[k].fmt, 8'h00, rows[k].route, 8'h00}, 4, ok);
            `CHK(ok, 1'b1)
            `CHK(format, rows[k].fmt)
            u_host.write_regs(ADDR_STRAP_HIGH, REG_ENABLE, {56'h0, rows[k].en}, 1, ok);
            pulse_event(rows[k].evt);
            `CHK(irq_first, rows[k].first)
            `CHK(irq_second, rows[k].second)
            u_host.read_regs(ADDR_STRAP_HIGH, REG_CAUSE, 1, rd, ok);
            `CHK(rd[7:0], rows[k].evt & rows[k].en)
            `CHK(irq_first, rows[k].fmt[FMT_INVERT_BIT])
            `CHK(irq_second, rows[k].fmt[FMT_INVERT_BIT])
        end
        // Data flag survives the cause read, falls on a data read
        data_cond = 8'h80;
        u_host.write_regs(ADDR_STRAP_HIGH, REG_ENABLE, 64'h80, 1, ok);
        `CHK(irq_first, 1'b1)
        u_host.read_regs(ADDR_STRAP_HIGH, REG_DATA_FIRST, 6, rd, ok);
        `CHK(rd[47:0], sample)
        `CHK(data_pulses, 6)
        `CHK(irq_first, 1'b1)
        data_cond = 8'h00;
        settle(4);
        `CHK(irq_first, 1'b1)
        u_host.read_regs(ADDR_STRAP_HIGH, REG_CAUSE, 1, rd, ok);
        `CHK(rd[7:0], 8'h80)
        `CHK(irq_first, 1'b1)
        u_host.read_regs(ADDR_STRAP_HIGH, REG_DATA_FIRST, 1, rd, ok);
        `CHK(irq_first, 1'b0)
        // Port idle without chip select, and deaf to foreign addresses
        cs = 1'b0;
        u_host.write_regs(ADDR_STRAP_HIGH, REG_FORMAT, 64'h20, 1, ok);
        `CHK(ok, 1'b0)
        `CHK(format, 8'h00)
        cs = 1'b1;
        u_host.write_regs(7'h2A, REG_FORMAT, 64'h20, 1, ok);
        `CHK(ok, 1'b0)
        // Strap is taken during reset only
        strap = 1'b0;
        rst_n = 1'b0;
        settle(20);
        rst_n = 1'b1;
        settle(5);
        `CHK(format, FORMAT_RST)
        u_host.write_regs(ADDR_STRAP_HIGH, REG_FORMAT, 64'h20, 1, ok);
        `CHK(ok, 1'b0)
        u_host.read_regs(ADDR_STRAP_LOW, REG_ENABLE, 4, rd, ok);
        `CHK(ok, 1'b1)
        `CHK(rd[31:0], {FORMAT_RST, FLAGS_RST, ROUTE_RST, ENABLE_RST})
        u_host.write_regs(ADDR_STRAP_LOW, REG_FORMAT, 64'h20, 1, ok);
        `CHK(format, 8'h20)
        `CHK(irq_second, 1'b1)
        `CHK(data_pulses, 7)
        print_verdict();
    end
endmodule : ipl_port_irq_tb
